// file: classifier_match_defs.svh
// Register offsets, field positions and reset values for the classifier match block
`ifndef CLASSIFIER_MATCH_DEFS_SVH
`define CLASSIFIER_MATCH_DEFS_SVH

`define FIRST_IPV6_ADDR_127_96_OFF 12'h060
`define FIRST_IPV6_ADDR_95_64_OFF 12'h064
`define FIRST_IPV6_ADDR_63_32_OFF 12'h068
`define FIRST_IPV6_ADDR_31_0_OFF 12'h06c
`define SECOND_IPV6_ADDR_127_96_OFF 12'h070
`define SECOND_IPV6_ADDR_95_64_OFF 12'h074
`define SECOND_IPV6_ADDR_63_32_OFF 12'h078
`define SECOND_IPV6_ADDR_31_0_OFF 12'h07c
`define OAM_CONTROL_WORD_MATCH_OFF 12'h080
`define FIFO_PEAK_LEVELS_OFF 12'h0d4

`define OAM_MASK_MSB 31
`define OAM_MASK_LSB 16
`define OAM_VALUE_MSB 15
`define OAM_VALUE_LSB 0
`define TX_PEAK_MSB 31
`define TX_PEAK_LSB 25
`define RX_PEAK_MSB 9
`define RX_PEAK_LSB 0

`define REG_RESET_VALUE 32'h0000_0000
`define TX_PEAK_RESET 7'h00
`define RX_PEAK_RESET 10'h000

`endif

// file: classifier_match_pkg.sv
// Types shared by the classifier match and peak files
package classifier_match_pkg;
    typedef logic [31:0] word_t;
    typedef logic [127:0] ipv6_addr_t;
    typedef logic [6:0] tx_level_t;
    typedef logic [9:0] rx_level_t;
    typedef enum logic [1:0] {
        ADDR_NONE = 2'b00,
        ADDR_FIRST = 2'b01,
        ADDR_SECOND = 2'b10,
        ADDR_BOTH = 2'b11
    } addr_hit_t;
endpackage : classifier_match_pkg

// file: fifo_peak_tracker.sv
// Peak-level tracker with clear-on-read for one FIFO level
`timescale 1ns/1ps
`default_nettype none
module fifo_peak_tracker #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Level and clear
    input wire logic [WIDTH-1:0] i_level,
    input wire logic i_clear,
    // Peak
    output logic [WIDTH-1:0] o_peak
);
    wire logic level_above;
    wire logic [WIDTH-1:0] next_peak;

    assign level_above = i_level > o_peak;
    // Clear restarts from the present level so a coincident level is not lost
    assign next_peak = i_clear ? i_level : (level_above ? i_level : o_peak);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_peak <= '0;
        end else begin
            o_peak <= next_peak;
        end
    end

    a_peak_tracks_max: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !$past(i_clear) && $past(i_rst_n) |-> o_peak >= $past(i_level)) else $error("peak below last level");
    a_peak_clear_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_clear |=> o_peak == $past(i_level)) else $error("clear did not load level");
endmodule : fifo_peak_tracker
`default_nettype wire

// file: classifier_match_regs.sv
// APB register bank for classifier address match, OAM match and FIFO peaks
//
// Functional notes
// - Second IPv6 address matched only on Ethernet packets
// - OAM hit when masked control word bits match
// - Bits 31:25 hold transmit FIFO peak
// - Bits 9:0 hold receive FIFO peak
// - Reading peak register clears both peaks
// - First IPv6 address is separate 128-bit group
`timescale 1ns/1ps
`default_nettype none
`include "classifier_match_defs.svh"
module classifier_match_regs (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Packet under classification
    input wire logic i_pkt_valid,
    input wire logic i_pkt_from_ethernet,
    input wire logic [127:0] i_pkt_dest_ipv6,
    input wire logic [15:0] i_pkt_ctrl_word_msbs,
    // FIFO levels in dwords
    input wire logic [6:0] i_tx_fifo_level,
    input wire logic [9:0] i_rx_fifo_level,
    // Classification results
    output logic o_first_addr_hit,
    output logic o_second_addr_hit,
    output logic o_oam_hit,
    output logic [127:0] o_first_ipv6_addr,
    output logic [127:0] o_second_ipv6_addr,
    output logic [15:0] o_oam_ctrlword_compare_mask,
    output logic [15:0] o_oam_ctrlword_match_value
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    classifier_match_pkg::word_t first_ipv6_addr_words [4];
    classifier_match_pkg::word_t second_ipv6_addr_words [4];
    classifier_match_pkg::word_t oam_control_word_match;
    classifier_match_pkg::tx_level_t tx_peak;
    classifier_match_pkg::rx_level_t rx_peak;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire logic apb_setup;
    wire logic apb_access;
    wire logic apb_wr;
    wire logic apb_rd;
    wire logic sel_oam;
    wire logic sel_peak;
    wire logic sel_first [4];
    wire logic sel_second [4];
    wire logic addr_mapped;
    wire logic [31:0] wr_mask;

    assign apb_setup = i_psel && !i_penable;
    assign apb_access = i_psel && i_penable;
    assign apb_wr = apb_access && i_pwrite;
    assign apb_rd = apb_access && !i_pwrite;
    assign sel_oam = i_paddr == `OAM_CONTROL_WORD_MATCH_OFF;
    assign sel_peak = i_paddr == `FIFO_PEAK_LEVELS_OFF;
    assign wr_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

    // One access cycle per transfer; no wait states are ever inserted
    assign o_pready = apb_access;

    // Both address word groups share one generate loop, first group ends at 0x6C
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_addr_words
            assign sel_first[gi] = i_paddr == (`FIRST_IPV6_ADDR_127_96_OFF + 12'(4 * gi));
            assign sel_second[gi] = i_paddr == (`SECOND_IPV6_ADDR_127_96_OFF + 12'(4 * gi));

            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    first_ipv6_addr_words[gi] <= `REG_RESET_VALUE;
                    second_ipv6_addr_words[gi] <= `REG_RESET_VALUE;
                end else if (apb_wr) begin
                    if (sel_first[gi]) begin
                        first_ipv6_addr_words[gi] <= (first_ipv6_addr_words[gi] & ~wr_mask) | (i_pwdata & wr_mask);
                    end
                    if (sel_second[gi]) begin
                        second_ipv6_addr_words[gi] <= (second_ipv6_addr_words[gi] & ~wr_mask) | (i_pwdata & wr_mask);
                    end
                end
            end
        end
    endgenerate

    assign addr_mapped = sel_oam || sel_peak || sel_first[0] || sel_first[1] || sel_first[2] || sel_first[3]
        || sel_second[0] || sel_second[1] || sel_second[2] || sel_second[3];

    ////////////////////////////////////////////////////////////////////////////////
    // OAM match register

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            oam_control_word_match <= `REG_RESET_VALUE;
        end else if (apb_wr && sel_oam) begin
            oam_control_word_match <= (oam_control_word_match & ~wr_mask) | (i_pwdata & wr_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Peak levels, cleared by a completed read of the peak register

    wire logic peak_clear;
    assign peak_clear = apb_rd && sel_peak;

    fifo_peak_tracker #(.WIDTH(7)) u_tx_peak (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_tx_fifo_level),
        .i_clear(peak_clear),
        .o_peak(tx_peak)
    );

    fifo_peak_tracker #(.WIDTH(10)) u_rx_peak (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_rx_fifo_level),
        .i_clear(peak_clear),
        .o_peak(rx_peak)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, registered in the setup cycle so it is stable in access

    wire logic [31:0] peak_word;
    wire logic [31:0] next_prdata;

    // Writes to the peak register are ignored; reserved bits read as zero
    assign peak_word = {tx_peak, 15'h0000, rx_peak};
    assign next_prdata = sel_oam ? oam_control_word_match :
        sel_peak ? peak_word :
        sel_first[0] ? first_ipv6_addr_words[0] :
        sel_first[1] ? first_ipv6_addr_words[1] :
        sel_first[2] ? first_ipv6_addr_words[2] :
        sel_first[3] ? first_ipv6_addr_words[3] :
        sel_second[0] ? second_ipv6_addr_words[0] :
        sel_second[1] ? second_ipv6_addr_words[1] :
        sel_second[2] ? second_ipv6_addr_words[2] :
        sel_second[3] ? second_ipv6_addr_words[3] : 32'h0000_0000;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_prdata <= `REG_RESET_VALUE;
            o_pslverr <= 1'b0;
        end else if (apb_setup) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
            o_pslverr <= !addr_mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Classification

    wire logic [127:0] next_first_addr;
    wire logic [127:0] next_second_addr;
    wire logic [15:0] oam_mask;
    wire logic [15:0] oam_value;
    wire logic first_eq;
    wire logic second_eq;
    wire logic oam_eq;

    assign next_first_addr = {first_ipv6_addr_words[0], first_ipv6_addr_words[1],
        first_ipv6_addr_words[2], first_ipv6_addr_words[3]};
    assign next_second_addr = {second_ipv6_addr_words[0], second_ipv6_addr_words[1],
        second_ipv6_addr_words[2], second_ipv6_addr_words[3]};
    assign oam_mask = oam_control_word_match[`OAM_MASK_MSB:`OAM_MASK_LSB];
    assign oam_value = oam_control_word_match[`OAM_VALUE_MSB:`OAM_VALUE_LSB];
    assign first_eq = i_pkt_dest_ipv6 == next_first_addr;
    assign second_eq = i_pkt_dest_ipv6 == next_second_addr;
    // Mask bit set means compare that bit
    assign oam_eq = ((i_pkt_ctrl_word_msbs ^ oam_value) & oam_mask) == 16'h0000;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_first_addr_hit <= 1'b0;
            o_second_addr_hit <= 1'b0;
            o_oam_hit <= 1'b0;
        end else begin
            // Only Ethernet-received packets are matched against the addresses
            o_first_addr_hit <= i_pkt_valid && i_pkt_from_ethernet && first_eq;
            o_second_addr_hit <= i_pkt_valid && i_pkt_from_ethernet && second_eq;
            o_oam_hit <= i_pkt_valid && oam_eq;
        end
    end

    assign o_first_ipv6_addr = next_first_addr;
    assign o_second_ipv6_addr = next_second_addr;
    assign o_oam_ctrlword_compare_mask = oam_mask;
    assign o_oam_ctrlword_match_value = oam_value;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    a_second_eth_only: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_second_addr_hit |-> $past(i_pkt_from_ethernet) && $past(i_pkt_valid)) else $error("second hit off ethernet");
    a_second_addr_hit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_pkt_valid && i_pkt_from_ethernet && i_pkt_dest_ipv6 == o_second_ipv6_addr) |=> o_second_addr_hit)
        else $error("second address missed");
    a_oam_match: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_pkt_valid |=> o_oam_hit == ((($past(i_pkt_ctrl_word_msbs) ^ $past(o_oam_ctrlword_match_value))
        & $past(o_oam_ctrlword_compare_mask)) == 16'h0000)) else $error("oam match wrong");
    a_tx_peak_field: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_setup && !i_pwrite && sel_peak) |=> o_prdata[31:25] == $past(tx_peak)) else $error("tx peak field");
    a_rx_peak_field: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_setup && !i_pwrite && sel_peak) |=> o_prdata[9:0] == $past(rx_peak)) else $error("rx peak field");
    a_peak_read_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        peak_clear |=> rx_peak == $past(i_rx_fifo_level) && tx_peak == $past(i_tx_fifo_level))
        else $error("peak not cleared");
    a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_setup && !i_pwrite && sel_peak) |=> o_prdata[24:10] == 15'h0000) else $error("reserved bits set");
    a_first_end_word: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_wr && i_paddr == `FIRST_IPV6_ADDR_31_0_OFF && i_pstrb == 4'hf) |=> o_first_ipv6_addr[31:0] == $past(i_pwdata))
        else $error("first addr low word");
    a_pready_access: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_pready == (i_psel && i_penable)) else $error("pready wrong");

    // Address hits never come from a packet off another port
    a_first_eth_only: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_first_addr_hit |-> $past(i_pkt_from_ethernet) && $past(i_pkt_valid)) else $error("first hit off ethernet");
    a_oam_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_pkt_valid |=> !o_oam_hit) else $error("oam hit without packet");
    a_pslverr_unmapped: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_setup && !addr_mapped) |=> o_pslverr) else $error("unmapped address not flagged");
    a_pslverr_mapped: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_setup && addr_mapped) |=> !o_pslverr) else $error("mapped address flagged");
    a_write_reads_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_setup && i_pwrite) |=> o_prdata == 32'h0000_0000) else $error("read data on write");
    a_pready_setup_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        apb_setup |-> !o_pready) else $error("pready in setup");
    a_second_low_word: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_wr && i_paddr == `SECOND_IPV6_ADDR_31_0_OFF && i_pstrb == 4'hf)
        |=> o_second_ipv6_addr[31:0] == $past(i_pwdata)) else $error("second addr low word");
    a_oam_reg_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (apb_wr && sel_oam && i_pstrb == 4'hf)
        |=> {o_oam_ctrlword_compare_mask, o_oam_ctrlword_match_value} == $past(i_pwdata)) else $error("oam write");
    // Without a clearing read a peak may only grow
    a_rx_peak_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !$past(peak_clear) && $past(i_rst_n) |-> rx_peak >= $past(rx_peak)) else $error("rx peak dropped");
    a_tx_peak_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !$past(peak_clear) && $past(i_rst_n) |-> tx_peak >= $past(tx_peak)) else $error("tx peak dropped");
endmodule : classifier_match_regs
`default_nettype wire

// file: apb_host_model.sv
// APB host model that issues register transfers to the classifier bank
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
    // Clock
    input wire logic i_ref_clk,
    // APB master side
    output var logic o_psel,
    output var logic o_penable,
    output var logic o_pwrite,
    output var logic [11:0] o_paddr,
    output var logic [31:0] o_pwdata,
    output var logic [3:0] o_pstrb,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0000_0000;
        o_pstrb = 4'h0;
    end

    // Starts on an edge of its own, so psel is never assigned twice in one step
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic er, output logic ok);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pstrb <= s;
        o_pwdata <= (a == 12'h0d4) ? (d & 32'hfe00_03ff) : d;
        @(posedge i_ref_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_pready !== 1'b1 && n < 16);
        ok = (i_pready === 1'b1);
        rd = i_prdata;
        er = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// file: classifier_match_and_fifo_peak_tb_top.sv
// Self-checking bench for the classifier match and FIFO peak register bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module classifier_match_and_fifo_peak_tb_top;
    logic i_ref_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, pkt_valid, pkt_eth;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, r, exp_rd;
    logic [3:0] pstrb;
    classifier_match_pkg::ipv6_addr_t dest, o_first, o_second;
    logic [15:0] ctrl, o_mask, o_value;
    logic [6:0] tx_lvl, m_tx;
    logic [9:0] rx_lvl, m_rx;
    logic hit1, hit2, hit_oam, e_first, e_second, e_oam, exp_err, clr;
    logic [31:0] m_reg [0:8];
    int n_errors = 0;
    int checks_done = 0;
    wire logic [127:0] first_addr = {m_reg[0], m_reg[1], m_reg[2], m_reg[3]};
    wire logic [127:0] second_addr = {m_reg[4], m_reg[5], m_reg[6], m_reg[7]};

    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    apb_host_model u_apb_host_model (.i_ref_clk(i_ref_clk), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb), .i_pready(pready),
        .i_prdata(prdata), .i_pslverr(pslverr));
    classifier_match_regs u_classifier_match_regs (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_pkt_valid(pkt_valid),
        .i_pkt_from_ethernet(pkt_eth), .i_pkt_dest_ipv6(dest), .i_pkt_ctrl_word_msbs(ctrl),
        .i_tx_fifo_level(tx_lvl), .i_rx_fifo_level(rx_lvl), .o_first_addr_hit(hit1), .o_second_addr_hit(hit2),
        .o_oam_hit(hit_oam), .o_first_ipv6_addr(o_first), .o_second_ipv6_addr(o_second),
        .o_oam_ctrlword_compare_mask(o_mask), .o_oam_ctrlword_match_value(o_value));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] rd_val(input logic [11:0] a);
        if (a == 12'h0d4) return {m_tx, 15'h0000, m_rx};
        if (a >= 12'h060 && a <= 12'h080) return m_reg[(a - 12'h060) >> 2];
        return 32'h0000_0000;
    endfunction : rd_val

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model, updated on the same edges as the bank
    always @(posedge i_ref_clk) begin
        clr = psel && penable && !pwrite && paddr == 12'h0d4;
        if (!i_rst_n) begin
            for (int k = 0; k < 9; k++) m_reg[k] <= 32'h0000_0000;
            {m_tx, m_rx, e_first, e_second, e_oam, exp_err, exp_rd} <= '0;
        end else begin
            if (psel && !penable) begin
                exp_err <= !((paddr >= 12'h060 && paddr <= 12'h080) || paddr == 12'h0d4);
                exp_rd <= pwrite ? 32'h0000_0000 : rd_val(paddr);
            end
            if (psel && penable && pwrite && paddr >= 12'h060 && paddr <= 12'h080)
                for (int b = 0; b < 4; b++) if (pstrb[b]) m_reg[(paddr - 12'h060) >> 2][8*b+:8] <= pwdata[8*b+:8];
            m_tx <= (clr || tx_lvl > m_tx) ? tx_lvl : m_tx;
            m_rx <= (clr || rx_lvl > m_rx) ? rx_lvl : m_rx;
            e_first <= pkt_valid && pkt_eth && dest == first_addr;
            e_second <= pkt_valid && pkt_eth && dest == second_addr;
            e_oam <= pkt_valid && ((ctrl ^ m_reg[8][15:0]) & m_reg[8][31:16]) == 16'h0000;
        end
    end

    always @(negedge i_ref_clk) begin
        if (i_rst_n === 1'b1) begin
            `CHECK(hit1, e_first)
            `CHECK(hit2, e_second)
            `CHECK(hit_oam, e_oam)
            `CHECK(o_first, first_addr)
            `CHECK(o_second, second_addr)
            `CHECK({o_mask, o_value}, m_reg[8])
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Packet and level stimulus; hits are steered in often so they really occur
    always @(posedge i_ref_clk) begin
        r = rnd();
        pkt_valid <= r[0] | r[1];
        pkt_eth <= r[2] | r[3];
        dest <= r[5] ? (r[4] ? first_addr : second_addr) : {rnd(), rnd(), rnd(), rnd()};
        ctrl <= r[6] ? m_reg[8][15:0] ^ (rnd() & ~m_reg[8][31:16]) : rnd();
        tx_lvl <= r[22:16] >> r[25:23];
        rx_lvl <= r[9:0] >> r[13:10];
    end

    task automatic op(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic er, ok;
        u_apb_host_model.xfer(a, w, d, s, rd, er, ok);
        `CHECK(ok, 1'b1)
        `CHECK(rd, exp_rd)
        `CHECK(er, exp_err)
    endtask : op

    task automatic tally_and_finish();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        seed = 32'h0000_3f72;
        {i_rst_n, pkt_valid, pkt_eth, dest, ctrl, tx_lvl, rx_lvl} = '0;
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        // Reset values, unmapped holes included
        for (int a = 12'h060; a <= 12'h0d4; a += 4) op(a[11:0], 1'b0, 32'h0000_0000, 4'h0);
        repeat (80) begin
            r = rnd();
            op((r[3:0] > 8) ? 12'h0d4 : 12'h060 + 12'(r[3:0]) * 4, 1'b1, rnd(), r[8] ? 4'hf : r[7:4]);
            op(12'h060 + 12'(r[11:9]) * 4, 1'b0, 32'h0000_0000, 4'h0);
            op(12'h0d4, 1'b0, 32'h0000_0000, 4'h0);
        end
        // Single-address setup: second address mirrors the first
        for (int k = 0; k < 4; k++) op(12'h070 + 12'(k) * 4, 1'b1, m_reg[k], 4'hf);
        repeat (200) @(posedge i_ref_clk);
        repeat (20) op(12'h0d4, 1'b0, 32'h0000_0000, 4'h0);
        op(12'hffc, 1'b1, rnd(), 4'hf);
        op(12'hffc, 1'b0, 32'h0000_0000, 4'h0);
        tally_and_finish();
    end
endmodule : classifier_match_and_fifo_peak_tb_top
`default_nettype wire
